// [rtl/noise_filter.v]
// Four-sample majority-free noise filter with bypass, feeding the edge detector
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.vh"
module noise_filter
(
   input wire hclk,
   input wire hresetn,
   input wire enable,
   input wire din,
   output wire dout
);
   reg [`FILTER_SAMPLES-1:0] hist_q; // Last four samples
   reg filt_q; // Filtered level
   reg raw_q; // Unfiltered level, keeps bypass path timing fixed
   // filt_q changes only when all four samples agree
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hist_q <= {`FILTER_SAMPLES{1'b0}};
         filt_q <= 1'b0;
         raw_q <= 1'b0;
      end
      else
      begin
         hist_q <= {hist_q[`FILTER_SAMPLES-2:0], din};
         raw_q <= din;
         if (&hist_q)
            filt_q <= 1'b1;
         else if (~|hist_q)
            filt_q <= 1'b0;
      end
   end
   // The filter costs four extra cycles against the bypass
   assign dout = enable ? filt_q : raw_q;
endmodule // noise_filter
`default_nettype wire

// [rtl/sync2.v]
// Two-flip-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2
(
   input wire hclk,
   input wire hresetn,
   input wire din,
   output wire dout
);
   reg meta_q; // First stage, read only by the second
   reg sync_q; // Settled level
   // Shift the raw level through two stages
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule // sync2
`default_nettype wire

// [rtl/timer16_capture.v]
// 16-bit timer/counter with shared high-byte staging and input capture, AHB-Lite slave
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.vh"
module timer16_capture
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire timer_tick,
   input wire capture_pin,
   input wire comparator_output,
   input wire overflow_serviced,
   input wire capture_serviced,
   output wire overflow_irq,
   output wire capture_irq,
   output wire bottom,
   output wire top
);
   // Address phase capture
   reg wr_pend_q; // Write data phase pending
   reg [7:0] addr_q; // Latched word offset
   reg [31:0] rdata_q; // Registered read data
   wire take; // Valid address phase accepted
   wire rd_now; // Read accepted this cycle
   wire wr_now; // Write data present this cycle
   wire [7:0] wb; // Written byte
   // Register state
   reg [15:0] count_value_q; // The counter
   reg [15:0] capture_value_q; // Capture register
   reg [15:0] compare_a_q; // Compare value A
   reg [15:0] compare_b_q; // Compare value B
   reg [7:0] staging_q; // Shared high-byte staging register
   reg [7:0] timer_ctrl_a_q; // Control A
   reg [7:0] timer_ctrl_b_q; // Control B
   reg comparator_capture_select_q; // Trigger source select
   reg overflow_flag_q; // Overflow flag
   reg capture_flag_q; // Capture flag
   reg [1:0] irq_mask_q; // Interrupt enables
   reg down_q; // Counting direction in dual-slope modes
   // Combinational helpers
   wire [3:0] waveform_mode; // Mode field from both control registers
   reg [15:0] top_val; // Top of the count sequence
   wire running; // Clock select nonzero
   wire tick_s; // Synchronised timer tick level
   reg tick_prev_q; // For rising-edge detect of the tick
   wire tick; // One pulse per timer clock
   wire pin_s; // Synchronised capture pin
   wire cmp_s; // Synchronised comparator output
   localparam N_ASYNC = 3; // Levels that cross into the bus clock
   wire [N_ASYNC-1:0] async_in; // Raw tick, pin and comparator levels
   wire [N_ASYNC-1:0] async_s; // The same levels after two flops
   wire trig_src; // Selected trigger
   wire trig_f; // Filtered trigger
   reg trig_prev_q; // Previous filtered trigger
   wire cap_event; // Qualified capture edge
   wire icr_top; // Mode uses capture register as top
   wire dual; // Dual-slope mode
   reg [15:0] count_d; // Next count
   reg down_d; // Next direction
   reg ovf_set; // Overflow event this cycle

   // True when a mode code takes its top from the capture register
   // One decode feeds both the top mux and the capture gate
   function is_icr_top;
      input [3:0] m;
      begin
         is_icr_top = (m == `WGM_PFC_ICR) || (m == `WGM_PC_ICR)
            || (m == `WGM_CTC_ICR) || (m == `WGM_FAST_ICR);
      end
   endfunction

   assign waveform_mode = {timer_ctrl_b_q[`CTB_WGM_HI], timer_ctrl_a_q[`CTA_WGM_LO]};
   assign icr_top = is_icr_top(waveform_mode);
   assign running = |timer_ctrl_b_q[`CTB_CLKSEL];
   // Modes 1-3, 8-11 count up and down
   assign dual = (waveform_mode[3:2] == 2'b10) || (waveform_mode[3:2] == 2'b00
      && waveform_mode[1:0] != 2'b00);

   // Top selection per mode. Fixed tops come from the low mode bits, then
   // the capture or compare register overrides them where the mode says so,
   // so a change of mode moves the top at once.
   always @*
   begin
      case (waveform_mode[1:0])
         2'b01: top_val = `TOP_8BIT;
         2'b10: top_val = `TOP_9BIT;
         2'b11: top_val = `TOP_10BIT;
         default: top_val = `TOP_MAX;
      endcase
      if (icr_top)
         top_val = capture_value_q;
      else if (waveform_mode == `WGM_CTC_OCR || waveform_mode[3:2] == 2'b10
         || waveform_mode == 4'hb || waveform_mode == 4'hf)
         top_val = compare_a_q;
      else if (waveform_mode == `WGM_NORMAL)
         top_val = `TOP_MAX;
   end

   // Bus decode: a single always-ready slave. An address phase taken at one
   // edge has its read data registered at that edge, so the byte stands for
   // the whole data phase. Writes are latched by offset and land at the end
   // of the data phase, when hwdata is valid. Only the low byte lane carries
   // data; each 8-bit location sits in its own aligned word.
   assign take = hsel && hready && htrans[1];
   assign rd_now = take && !hwrite;
   assign wr_now = wr_pend_q;
   assign wb = hwdata[7:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // Address latch and registered read data
   // The offset follows haddr every cycle; only wr_pend_q says that it matters
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= take && hwrite;
         addr_q <= haddr[7:0];
         rdata_q <= 32'h0000_0000;
         if (rd_now)
         begin
            // Unused byte lanes read as zero, so no stale bits leak out
            case (haddr[7:0])
               `OFS_COUNT_LOW: rdata_q[7:0] <= count_value_q[7:0];
               `OFS_COUNT_HIGH: rdata_q[7:0] <= staging_q;
               `OFS_CAPTURE_LOW: rdata_q[7:0] <= capture_value_q[7:0];
               `OFS_CAPTURE_HIGH: rdata_q[7:0] <= staging_q;
               `OFS_COMPARE_A_LOW: rdata_q[7:0] <= compare_a_q[7:0];
               `OFS_COMPARE_A_HIGH: rdata_q[7:0] <= compare_a_q[15:8];
               `OFS_COMPARE_B_LOW: rdata_q[7:0] <= compare_b_q[7:0];
               `OFS_COMPARE_B_HIGH: rdata_q[7:0] <= compare_b_q[15:8];
               `OFS_CTRL_A: rdata_q[7:0] <= timer_ctrl_a_q;
               `OFS_CTRL_B: rdata_q[7:0] <= timer_ctrl_b_q;
               `OFS_FLAGS: rdata_q[1:0] <= {capture_flag_q, overflow_flag_q};
               `OFS_IRQ_MASK: rdata_q[1:0] <= irq_mask_q;
               `OFS_CMP_CTRL: rdata_q[0] <= comparator_capture_select_q;
               `OFS_STATUS: rdata_q[0] <= down_q;
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Tick, pin and comparator levels come from outside; each passes two
   // flops before anything reads it
   assign async_in = {comparator_output, capture_pin, timer_tick};
   genvar gi;
   generate
      for (gi = 0; gi < N_ASYNC; gi = gi + 1)
      begin : g_sync
         sync2 u_sync
         (
            .hclk(hclk),
            .hresetn(hresetn),
            .din(async_in[gi]),
            .dout(async_s[gi])
         );
      end
   endgenerate
   assign tick_s = async_s[0];
   assign pin_s = async_s[1];
   assign cmp_s = async_s[2];
   // One pulse per rising tick edge, and none while the clock select is zero
   assign tick = tick_s && !tick_prev_q && running;
   // The comparator output replaces the pin as trigger when selected
   assign trig_src = comparator_capture_select_q ? cmp_s : pin_s;

   noise_filter u_filt
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(timer_ctrl_b_q[`CTB_FILTER]),
      .din(trig_src),
      .dout(trig_f)
   );

   // Edge detector, gated off when the capture register is the top. In
   // those modes the pin is free for other use, and a stray edge must not
   // overwrite the top value.
   assign cap_event = !icr_top && (trig_f != trig_prev_q)
      && (trig_f == timer_ctrl_b_q[`CTB_EDGE]);

   // Counter next state. Dual-slope modes turn at top and flag overflow
   // at bottom; single-slope modes wrap to bottom at top. A CPU count write in
   // the clocked process below overrides the count and direction this process
   // chooses, so a write that meets a tick never loses to the count.
   always @*
   begin
      count_d = count_value_q;
      down_d = down_q;
      ovf_set = 1'b0;
      if (tick)
      begin
         if (dual)
         begin
            if (!down_q && count_value_q >= top_val)
            begin
               down_d = 1'b1;
               count_d = count_value_q - 16'h0001;
               ovf_set = 1'b0; // Dual-slope overflow waits for bottom
            end
            else if (down_q && count_value_q == `BOTTOM_VAL)
            begin
               down_d = 1'b0;
               count_d = count_value_q + 16'h0001;
               ovf_set = 1'b1;
            end
            else
               count_d = down_q ? count_value_q - 16'h0001 : count_value_q + 16'h0001;
         end
         else if (count_value_q == top_val)
         begin
            count_d = `BOTTOM_VAL;
            // Clear-on-match modes wrap silently unless their top is the full range
            ovf_set = (waveform_mode != `WGM_CTC_OCR) && (waveform_mode != `WGM_CTC_ICR)
               || top_val == `TOP_MAX;
         end
         else
            count_d = count_value_q + 16'h0001;
      end
   end

   // Counter, staging, registers and flags
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Every register starts at zero, so the counter sits at bottom
         count_value_q <= 16'h0000;
         capture_value_q <= 16'h0000;
         compare_a_q <= 16'h0000;
         compare_b_q <= 16'h0000;
         staging_q <= 8'h00;
         timer_ctrl_a_q <= 8'h00;
         timer_ctrl_b_q <= 8'h00;
         comparator_capture_select_q <= 1'b0;
         overflow_flag_q <= 1'b0;
         capture_flag_q <= 1'b0;
         irq_mask_q <= 2'b00;
         down_q <= 1'b0;
         tick_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         tick_prev_q <= tick_s;
         trig_prev_q <= trig_f;
         count_value_q <= count_d;
         down_q <= down_d;
         // Count and capture low-byte reads stage the high byte. The staging byte is shared by
         // every 16-bit register, so software that writes another high byte, or reads
         // count or capture low, between the two halves of a pair corrupts that pair.
         if (rd_now && haddr[7:0] == `OFS_COUNT_LOW)
            staging_q <= count_value_q[15:8];
         if (rd_now && haddr[7:0] == `OFS_CAPTURE_LOW)
            staging_q <= capture_value_q[15:8];
         // Newest capture always wins the register
         // An unread capture is lost; software must read before the next edge
         if (cap_event)
            capture_value_q <= count_value_q;
         // Writes land from the latched offset at the end of the data phase
         if (wr_now)
         begin
            case (addr_q)
               `OFS_COUNT_HIGH, `OFS_CAPTURE_HIGH, `OFS_COMPARE_A_HIGH,
                  `OFS_COMPARE_B_HIGH: staging_q <= wb;
               `OFS_COUNT_LOW:
               begin
                  count_value_q <= {staging_q, wb};
                  down_q <= down_q;
               end
               `OFS_CAPTURE_LOW:
                  if (icr_top)
                     capture_value_q <= {staging_q, wb};
               `OFS_COMPARE_A_LOW: compare_a_q <= {staging_q, wb};
               `OFS_COMPARE_B_LOW: compare_b_q <= {staging_q, wb};
               `OFS_CTRL_A: timer_ctrl_a_q <= wb;
               `OFS_CTRL_B: timer_ctrl_b_q <= wb;
               `OFS_IRQ_MASK: irq_mask_q <= wb[1:0];
               `OFS_CMP_CTRL: comparator_capture_select_q <= wb[`CMPC_SELECT];
               default: irq_mask_q <= irq_mask_q;
            endcase
         end
         // Flags: set wins over write-one or service clear,
         // so an event in the same cycle as a clear is never lost
         if (ovf_set)
            overflow_flag_q <= 1'b1;
         else if ((wr_now && addr_q == `OFS_FLAGS && wb[`FLG_OVF]) || overflow_serviced)
            overflow_flag_q <= 1'b0;
         if (cap_event)
            capture_flag_q <= 1'b1;
         else if ((wr_now && addr_q == `OFS_FLAGS && wb[`FLG_CAP]) || capture_serviced)
            capture_flag_q <= 1'b0;
      end
   end

   // Requests are plain levels of flag and enable; the core's service pulse
   // clears the flag, which drops the request on the next cycle
   assign overflow_irq = overflow_flag_q && irq_mask_q[`FLG_OVF];
   assign capture_irq = capture_flag_q && irq_mask_q[`FLG_CAP];
   // Bottom and top are level views of the count for the mode logic
   assign bottom = (count_value_q == `BOTTOM_VAL);
   assign top = (count_value_q == top_val);
endmodule // timer16_capture
`default_nettype wire

// [rtl/timer16_map.vh]
// Register offsets, field positions, mode codes and timing counts of the 16-bit timer
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// Word offsets on the AHB-Lite bus, one 8-bit location per aligned word
`define OFS_COUNT_LOW 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_CAPTURE_LOW 8'h08
`define OFS_CAPTURE_HIGH 8'h0c
`define OFS_COMPARE_A_LOW 8'h10
`define OFS_COMPARE_A_HIGH 8'h14
`define OFS_COMPARE_B_LOW 8'h18
`define OFS_COMPARE_B_HIGH 8'h1c
`define OFS_CTRL_A 8'h20
`define OFS_CTRL_B 8'h24
`define OFS_FLAGS 8'h28
`define OFS_IRQ_MASK 8'h2c
`define OFS_CMP_CTRL 8'h30
`define OFS_STATUS 8'h34
// Control A fields
`define CTA_WGM_LO 1:0
// Control B fields
`define CTB_CLKSEL 2:0
`define CTB_WGM_HI 4:3
`define CTB_EDGE 6
`define CTB_FILTER 7
// Flag register fields (also the mask register and service strobes)
`define FLG_OVF 0
`define FLG_CAP 1
// Comparator control field
`define CMPC_SELECT 0
// Waveform mode codes; the first four use the capture register as top
`define WGM_PFC_ICR 4'h8
`define WGM_PC_ICR 4'ha
`define WGM_CTC_ICR 4'hc
`define WGM_FAST_ICR 4'he
`define WGM_NORMAL 4'h0
`define WGM_CTC_OCR 4'h4
// Fixed tops
`define TOP_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define BOTTOM_VAL 16'h0000
// Noise filter sample count
`define FILTER_SAMPLES 4
`endif

// [tb/cpu_model.sv]
// Processor-side bus master issuing single byte-location transfers
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic rd_seen,
   output logic [7:0] rd_val
);
   // Idle bus at time zero, word transfers only
   initial
   begin
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_seen = 1'h0;
      rd_val = 8'h0;
   end
   // Read strobe stands for one cycle only
   always @(posedge hclk)
      if (rd_seen)
         rd_seen <= 1'h0;
   // One master only, so no other access can split a byte pair
   task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= w ? {24'h0, d} : ~hwdata;
      do @(posedge hclk); while (hready !== 1'h1);
      rd_seen <= !w;
      rd_val <= hrdata[7:0];
      // Stale data and address are scrambled, never held
      hwdata <= ~hwdata;
      haddr <= ~haddr;
   endtask
endmodule // cpu_model
`default_nettype wire

// [tb/tb_timer16_counter_and_input_capture.sv]
// Self-checking bench for the 16-bit timer with input capture
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_counter_and_input_capture;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic timer_tick, capture_pin, comparator_output, overflow_serviced, capture_serviced;
   logic hsel, hwrite, rd_seen, hreadyout, hresp, overflow_irq, capture_irq, bottom, top;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] rd_val;
   logic [31:0] haddr, hwdata, hrdata;
   logic [31:0] lf = 32'h486d6b09; // Random source state
   logic [15:0] c, w; // Current and previous test values
   logic [7:0] q_exp [$]; // Expected read bytes, oldest first
   string q_nm [$]; // Names of the expected reads
   int err_total = 0;
   int comparisons = 0;
   always #50 hclk = ~hclk;
   cpu_model cpu
   (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .rd_seen(rd_seen), .rd_val(rd_val)
   );
   timer16_capture dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_tick(timer_tick),
      .capture_pin(capture_pin), .comparator_output(comparator_output),
      .overflow_serviced(overflow_serviced), .capture_serviced(capture_serviced),
      .overflow_irq(overflow_irq), .capture_irq(capture_irq), .bottom(bottom), .top(top)
   );
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task rnd;
      lf = step(lf);
      c = lf[15:0];
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e, input string n);
      comparisons = comparisons + 1;
      if (s !== e)
      begin
         err_total = err_total + 1;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      cpu.xfer(a, 1'h1, d);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input string n);
      q_exp.push_back(e);
      q_nm.push_back(n);
      cpu.xfer(a, 1'h0, 8'h0);
   endtask
   // High location first, low location commits the pair
   task wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a + 8'h04, d[15:8]);
      wr(a, d[7:0]);
   endtask
   // Low location first, high comes back from the staging byte for count and capture
   task rd16(input logic [7:0] a, input logic [15:0] e, input string n);
      rd(a, e[7:0], n);
      rd(a + 8'h04, e[15:8], n);
   endtask
   // Slow tick: high for three cycles and low for four, past the synchroniser
   task ticks(input int n);
      repeat (n)
      begin
         @(posedge hclk);
         timer_tick <= 1'h1;
         wait_n(3);
         timer_tick <= 1'h0;
         wait_n(3);
      end
   endtask
   // Trigger levels then enough time for sync, filter and edge stage
   task pin(input logic p, input logic q);
      @(posedge hclk);
      capture_pin <= p;
      comparator_output <= q;
      wait_n(14);
   endtask
   task svc(input logic o);
      @(posedge hclk);
      overflow_serviced <= o;
      capture_serviced <= !o;
      @(posedge hclk);
      overflow_serviced <= 1'h0;
      capture_serviced <= 1'h0;
      wait_n(2);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Each finished read takes the oldest expectation off the queue
   always @(posedge hclk)
      if (rd_seen === 1'h1)
         chk(rd_val, q_exp.pop_front(), q_nm.pop_front());
   // The run needs about four hundred cycles; ten thousand means a hang
   initial
   begin
      #1000000;
      err_total = err_total + 1;
      final_report;
   end
   initial
   begin
      timer_tick = 1'h0;
      capture_pin = 1'h0;
      comparator_output = 1'h0;
      overflow_serviced = 1'h0;
      capture_serviced = 1'h0;
      wait_n(6);
      hresetn <= 1'h1;
      rd(8'h00, 8'h00, "count_low_loc");
      chk({7'h0, bottom}, 8'h01, "bottom");
      chk({7'h0, hresp}, 8'h00, "hresp");
      rd(8'h38, 8'h00, "unmapped");
      rnd;
      wr16(8'h00, c);
      rd16(8'h00, c, "count_value");
      rd(8'h04, c[15:8], "count_high_loc");
      w = c;
      rnd;
      wr16(8'h10, c);
      rd(8'h00, w[7:0], "count_low_loc");
      rd(8'h14, c[15:8], "compare_values");
      wr(8'h04, 8'h5a);
      wr(8'h00, c[7:0]);
      wr(8'h18, c[7:0]);
      rd16(8'h00, {8'h5a, c[7:0]}, "count_value");
      rd16(8'h18, {8'h5a, c[7:0]}, "compare_values");
      $display("test access done");
      wr16(8'h00, 16'hfffe);
      wr(8'h2c, 8'h03);
      wr(8'h24, 8'h01);
      ticks(3);
      wr(8'h24, 8'h00);
      rd16(8'h00, 16'h0001, "count_value");
      rd(8'h28, 8'h01, "flags");
      chk({7'h0, overflow_irq}, 8'h01, "overflow_irq");
      svc(1'h1);
      chk({7'h0, overflow_irq}, 8'h00, "overflow_irq");
      wr(8'h20, 8'h01);
      wr16(8'h00, 16'h00ff);
      wr(8'h24, 8'h01);
      ticks(1);
      wr(8'h24, 8'h00);
      rd16(8'h00, 16'h00fe, "count_value");
      rd(8'h34, 8'h01, "status");
      rd(8'h28, 8'h00, "flags");
      wr(8'h20, 8'h00);
      $display("test count done");
      rnd;
      wr16(8'h00, c);
      wr(8'h24, 8'h40);
      pin(1'h1, 1'h0);
      rd16(8'h08, c, "capture_value");
      rd(8'h28, 8'h02, "flags");
      chk({7'h0, capture_irq}, 8'h01, "capture_irq");
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h02);
      rd(8'h28, 8'h00, "flags");
      rnd;
      wr16(8'h00, c);
      pin(1'h0, 1'h0);
      rd16(8'h08, c, "capture_value");
      chk({7'h0, capture_irq}, 8'h01, "capture_irq");
      svc(1'h0);
      chk({7'h0, capture_irq}, 8'h00, "capture_irq");
      $display("test capture done");
      wr(8'h30, 8'h01);
      wr(8'h24, 8'h40);
      wr(8'h28, 8'h02);
      rnd;
      wr16(8'h00, c);
      pin(1'h0, 1'h1);
      rd16(8'h08, c, "capture_value");
      wr(8'h30, 8'h00);
      wr(8'h24, 8'hc0);
      wr(8'h28, 8'h02);
      rnd;
      wr16(8'h00, c);
      @(posedge hclk);
      capture_pin <= 1'h1;
      wait_n(2);
      capture_pin <= 1'h0;
      wait_n(14);
      rd(8'h28, 8'h00, "flags");
      pin(1'h1, 1'h1);
      rd16(8'h08, c, "capture_value");
      $display("test filter done");
      w = c;
      rnd;
      wr16(8'h08, c);
      rd16(8'h08, w, "capture_value");
      wr(8'h20, 8'h00);
      wr(8'h24, 8'h18);
      wr(8'h28, 8'h02);
      wr16(8'h08, c);
      rd16(8'h08, c, "capture_value");
      wr16(8'h00, c);
      pin(1'h0, 1'h1);
      rd(8'h28, 8'h00, "flags");
      chk({7'h0, top}, 8'h01, "top");
      rd16(8'h08, c, "capture_value");
      $display("test capture top done");
      wait_n(4);
      final_report;
   end
endmodule // tb_timer16_counter_and_input_capture
`default_nettype wire

// [tb/timer16_chk.sv]
// Checker of the timer's interrupt, status and read-data outputs
`timescale 1ns/1ps
`default_nettype none
module timer16_chk
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hrdata,
   input wire logic timer_tick,
   input wire logic capture_pin,
   input wire logic comparator_output,
   input wire logic overflow_serviced,
   input wire logic capture_serviced,
   input wire logic overflow_irq,
   input wire logic capture_irq,
   input wire logic bottom,
   input wire logic top
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_a; // Write address phase on the bus
   logic [3:0] chg_q; // Age of the last trigger move, saturating
   assign wr_a = hsel && htrans[1] && hwrite;
   // Age counter lets a capture be traced back to its cause
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         chg_q <= 4'hf;
      else if ($changed(capture_pin) || $changed(comparator_output))
         chg_q <= 4'h0;
      else if (chg_q != 4'hf)
         chg_q <= chg_q + 4'h1;
   end
   // Six quiet cycles outlast the tick synchroniser and edge stage
   sequence calm_tick;
      (!wr_a && $stable(timer_tick))[*6];
   endsequence
   // Eight quiet cycles outlast synchroniser, filter and edge stage
   sequence calm_trig;
      (!wr_a && $stable(capture_pin) && $stable(comparator_output))[*8];
   endsequence
   a_reset_vals: assert property ($rose(hresetn) |-> bottom && !top && !capture_irq)
      else $error("wrong status after reset");
   a_narrow_read: assert property (hrdata[31:8] == 24'h0)
      else $error("read data wider than one byte");
   a_stopped_still: assert property (calm_tick |-> $stable(bottom) && $stable(top))
      else $error("count status moved without tick or write");
   a_ovf_clear: assert property (
      calm_tick ##1 (overflow_serviced && !wr_a) |=> !overflow_irq)
      else $error("overflow request kept after service");
   a_ovf_hold: assert property (
      overflow_irq && !overflow_serviced && !wr_a && !$past(wr_a) |=> overflow_irq)
      else $error("overflow request dropped by itself");
   a_cap_clear: assert property (
      calm_trig ##1 (capture_serviced && !wr_a) |=> !capture_irq)
      else $error("capture request kept after service");
   a_cap_hold: assert property (
      capture_irq && !capture_serviced && !wr_a && !$past(wr_a) |=> capture_irq)
      else $error("capture request dropped by itself");
   a_cap_cause: assert property (
      $rose(capture_irq) |-> chg_q < 4'hd || $past(wr_a, 2) || $past(wr_a, 3))
      else $error("capture request without a trigger change");
endmodule // timer16_chk
bind timer16_capture timer16_chk chk
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hrdata(hrdata), .timer_tick(timer_tick), .capture_pin(capture_pin),
   .comparator_output(comparator_output), .overflow_serviced(overflow_serviced),
   .capture_serviced(capture_serviced), .overflow_irq(overflow_irq),
   .capture_irq(capture_irq), .bottom(bottom), .top(top)
);
`default_nettype wire
